//--- pmt_pkg.sv
// Constants for the period match timer: register indices, field
// positions, reset values and the instruction clock divider.
// Assumes one clock domain (hclk) and an AHB-Lite register port.
//
// Contract
// - Counter counts up from 00h and wraps to 00h after matching the period.
// - Any reset loads the period register with all ones.
// - Reset clears the count; software may read and write it anytime.
// - Count and period registers are read/write; writes store directly.
// - Instruction clock feeds prescaler: 00 gives 1:1, 01 gives 1:4, 1x 1:16.
// - Match events pass a postscaler dividing by field plus one, bits 6:3.
// - Each postscaler pulse sets the flag at bit 1; it stays until cleared.
// - Count write, control write or reset clear prescaler and postscaler.
// - A control write leaves the count value unchanged.
// - Run bit 2 enables counting; when clear the count holds.
// - Match pulse before the postscaler goes out to the serial port.
// - Count value and match event go out to the PWM unit.
package pmt_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] PMT_IDX_INT_CTRL = 8'h0b;
   localparam logic [7:0] PMT_IDX_IRQ_FLAG = 8'h0c;
   localparam logic [7:0] PMT_IDX_COUNT    = 8'h11;
   localparam logic [7:0] PMT_IDX_CONTROL  = 8'h12;
   localparam logic [7:0] PMT_IDX_IRQ_EN   = 8'h8c;
   localparam logic [7:0] PMT_IDX_PERIOD   = 8'h92;

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PMT_CTL_PRE_LSB   = 0;
   localparam int PMT_CTL_RUN_BIT   = 2;
   localparam int PMT_CTL_POST_LSB  = 3;
   localparam int PMT_FLAG_TMR_BIT  = 1;
   localparam int PMT_INT_GLOB_BIT  = 7;
   localparam int PMT_INT_PERI_BIT  = 6;

   ////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] PMT_COUNT_RST   = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST  = 8'hff;
   localparam logic [6:0] PMT_CONTROL_RST = 7'h00;

   ////////////////////////////////////////////////////////////////////
   // Timing: hclk is the oscillator, the instruction clock is one in four
   localparam logic [1:0] PMT_INSTR_LAST  = 2'h3;
   localparam logic [3:0] PMT_PRE_LAST_1  = 4'h0;
   localparam logic [3:0] PMT_PRE_LAST_4  = 4'h3;
   localparam logic [3:0] PMT_PRE_LAST_16 = 4'hf;

   typedef enum logic [1:0] {
      PMT_BUS_IDLE,
      PMT_BUS_WRITE,
      PMT_BUS_RD_WAIT,
      PMT_BUS_RD_DONE
   } pmt_bus_state_t;

endpackage

//--- pmt_postscaler.sv
// Match postscaler: one pulse out per (sel + 1) match pulses in.
// Assumes match is a one-cycle strobe on hclk.
`timescale 1ns/1ps
module pmt_postscaler (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       match,
   input  wire logic       clear,
   input  wire logic [3:0] sel,
   output logic            pulse
);
   logic [3:0] cnt_q;

   assign pulse = match & ~clear & (cnt_q == sel);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 4'h0;
      end else if (clear) begin
         cnt_q <= 4'h0;
      end else if (match) begin
         // Sel may shrink below cnt; the wrap via 4'hf keeps it bounded
         cnt_q <= (cnt_q == sel) ? 4'h0 : cnt_q + 4'h1;
      end
   end
endmodule

//--- pmt_prescaler.sv
// Input prescaler for the period match timer.
// Assumes tick is a one-cycle strobe on hclk.
`timescale 1ns/1ps
module pmt_prescaler (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tick,
   input  wire logic       clear,
   input  wire logic [1:0] sel,
   output logic            pulse
);
   import pmt_pkg::*;

   logic [3:0] cnt_q;
   logic [3:0] last;

   always_comb begin
      case (sel)
         2'h0:    last = PMT_PRE_LAST_1;
         2'h1:    last = PMT_PRE_LAST_4;
         default: last = PMT_PRE_LAST_16;
      endcase
   end

   assign pulse = tick & ~clear & (cnt_q == last);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 4'h0;
      end else if (clear) begin
         cnt_q <= 4'h0;
      end else if (tick) begin
         cnt_q <= (cnt_q == last) ? 4'h0 : cnt_q + 4'h1;
      end
   end
endmodule

//--- pmt_timer.sv
// Period match timer: 8-bit counter, period register, prescaler,
// postscaler, interrupt flag and enables behind an AHB-Lite slave.
// Assumes a single AHB master, whole-word single transfers, hclk as
// the oscillator and hresetn as the merged device reset.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
module pmt_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic             irq,
   output logic             sync_serial_shift_tick,
   output logic             pwm_period_match,
   output logic [7:0]       pwm_timebase_count,
   output logic [7:0]       pwm_timebase_period
);
   import pmt_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Declarations

   pmt_bus_state_t bus_q;
   pmt_bus_state_t bus_d;

   logic [7:0]  idx_q;
   logic        mapped_q;
   logic [31:0] hrdata_q;

   logic [7:0]  count_q;
   logic [7:0]  count_d;
   logic [7:0]  period_q;
   logic [6:0]  control_q;
   logic        flag_q;
   logic        flag_d;
   logic        irq_en_q;
   logic        global_en_q;
   logic        periph_en_q;

   logic [1:0]  instr_phase_q;
   logic        instr_tick;
   logic        run;
   logic [1:0]  pre_sel;
   logic [3:0]  post_sel;

   logic        addr_valid;
   logic        addr_mapped;
   logic        wr_en;
   logic        wr_count;
   logic        wr_control;
   logic        wr_period;
   logic        wr_flags;
   logic        wr_irq_en;
   logic        wr_int_ctrl;
   logic        scaler_clear;
   logic        flag_clear;
   logic        rd_capture;
   logic        at_period;
   logic        pre_pulse;
   logic        match;
   logic        post_pulse;
   logic [7:0]  rd_mux;

   logic        shift_tick_q;
   logic        pwm_match_q;
   logic        irq_q;

   ////////////////////////////////////////////////////////////////////
   // Control fields

   assign run      = control_q[PMT_CTL_RUN_BIT];
   assign pre_sel  = control_q[PMT_CTL_PRE_LSB +: 2];
   assign post_sel = control_q[PMT_CTL_POST_LSB +: 4];

   ////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase

   // Whole words only: hsize is not checked, so a byte store writes the word
   assign addr_valid  = hsel & hready & htrans[1];
   assign addr_mapped = (haddr[31:10] == 22'h0)
                      & (haddr[1:0] == 2'h0)
                      & ((haddr[9:2] == PMT_IDX_INT_CTRL)
                       | (haddr[9:2] == PMT_IDX_IRQ_FLAG)
                       | (haddr[9:2] == PMT_IDX_COUNT)
                       | (haddr[9:2] == PMT_IDX_CONTROL)
                       | (haddr[9:2] == PMT_IDX_IRQ_EN)
                       | (haddr[9:2] == PMT_IDX_PERIOD));

   // Reads take one wait state so a write just before is always seen
   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         PMT_BUS_IDLE,
         PMT_BUS_WRITE,
         PMT_BUS_RD_DONE: begin
            if (addr_valid) begin
               bus_d = hwrite ? PMT_BUS_WRITE : PMT_BUS_RD_WAIT;
            end else begin
               bus_d = PMT_BUS_IDLE;
            end
         end
         PMT_BUS_RD_WAIT: begin
            bus_d = PMT_BUS_RD_DONE;
         end
         default: begin
            bus_d = PMT_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_q <= PMT_BUS_IDLE;
      end else begin
         bus_q <= bus_d;
      end
   end

   assign rd_capture = (bus_q == PMT_BUS_RD_WAIT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_q <= 8'h00;
      end else if (addr_valid && !rd_capture) begin
         idx_q <= haddr[9:2];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mapped_q <= 1'b0;
      end else if (addr_valid && !rd_capture) begin
         mapped_q <= addr_mapped;
      end
   end

   assign hreadyout = ~rd_capture;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   ////////////////////////////////////////////////////////////////////
   // Write strobes, taken in the data phase

   assign wr_en       = (bus_q == PMT_BUS_WRITE) & mapped_q;
   assign wr_count    = wr_en & (idx_q == PMT_IDX_COUNT);
   assign wr_control  = wr_en & (idx_q == PMT_IDX_CONTROL);
   assign wr_period   = wr_en & (idx_q == PMT_IDX_PERIOD);
   assign wr_flags    = wr_en & (idx_q == PMT_IDX_IRQ_FLAG);
   assign wr_irq_en   = wr_en & (idx_q == PMT_IDX_IRQ_EN);
   assign wr_int_ctrl = wr_en & (idx_q == PMT_IDX_INT_CTRL);

   // Either write resets the scalers; a control write keeps the count
   assign scaler_clear = wr_count | wr_control;

   ////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      rd_mux = 8'h00;
      case (idx_q)
         PMT_IDX_INT_CTRL: begin
            rd_mux[PMT_INT_GLOB_BIT] = global_en_q;
            rd_mux[PMT_INT_PERI_BIT] = periph_en_q;
         end
         PMT_IDX_IRQ_FLAG: rd_mux[PMT_FLAG_TMR_BIT] = flag_q;
         PMT_IDX_COUNT:    rd_mux = count_q;
         PMT_IDX_CONTROL:  rd_mux = {1'b0, control_q};
         PMT_IDX_IRQ_EN:   rd_mux[PMT_FLAG_TMR_BIT] = irq_en_q;
         PMT_IDX_PERIOD:   rd_mux = period_q;
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_capture) begin
         hrdata_q <= mapped_q ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_q <= PMT_CONTROL_RST;
      end else if (wr_control) begin
         control_q <= hwdata[6:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_q <= PMT_PERIOD_RST;
      end else if (wr_period) begin
         period_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en_q <= 1'b0;
      end else if (wr_irq_en) begin
         irq_en_q <= hwdata[PMT_FLAG_TMR_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_en_q <= 1'b0;
      end else if (wr_int_ctrl) begin
         global_en_q <= hwdata[PMT_INT_GLOB_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periph_en_q <= 1'b0;
      end else if (wr_int_ctrl) begin
         periph_en_q <= hwdata[PMT_INT_PERI_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Instruction clock and prescaler

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_phase_q <= 2'h0;
      end else begin
         instr_phase_q <= instr_phase_q + 2'h1;
      end
   end

   // Gated before the prescaler so a stopped timer holds the prescaler still; instr_phase_q keeps counting
   assign instr_tick = (instr_phase_q == PMT_INSTR_LAST) & run;

   pmt_prescaler pmt_prescaler_i (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (instr_tick),
      .clear   (scaler_clear),
      .sel     (pre_sel),
      .pulse   (pre_pulse)
   );

   ////////////////////////////////////////////////////////////////////
   // Counter

   assign at_period = (count_q == period_q);
   assign match     = pre_pulse & at_period & ~wr_count;

   always_comb begin
      count_d = count_q;
      if (wr_count) begin
         count_d = hwdata[7:0];
      end else if (pre_pulse) begin
         count_d = match ? PMT_COUNT_RST : count_q + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= PMT_COUNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Postscaler and interrupt

   pmt_postscaler pmt_postscaler_i (
      .hclk    (hclk),
      .hresetn (hresetn),
      .match   (match),
      .clear   (scaler_clear),
      .sel     (post_sel),
      .pulse   (post_pulse)
   );

   // A set in the same cycle as a write-one clear wins, so no event is lost
   assign flag_clear = wr_flags & hwdata[PMT_FLAG_TMR_BIT];

   always_comb begin
      flag_d = flag_q;
      if (flag_clear) begin
         flag_d = 1'b0;
      end
      if (post_pulse) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Registered so an enable write never glitches the request line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_d & irq_en_q & periph_en_q & global_en_q;
      end
   end

   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////
   // Outputs to serial port and PWM unit

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_tick_q <= 1'b0;
      end else begin
         shift_tick_q <= match;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_match_q <= 1'b0;
      end else begin
         pwm_match_q <= match;
      end
   end

   assign sync_serial_shift_tick = shift_tick_q;
   assign pwm_period_match       = pwm_match_q;
   assign pwm_timebase_count     = count_q;
   assign pwm_timebase_period    = period_q;

endmodule

//--- pmt_timer_bench.sv
// Self-checking bench for the period match timer over AHB-Lite.
// Assumes the bench is the only master and the timer the only slave.
`timescale 1ns/1ps
module pmt_timer_bench;
   import pmt_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        irq;
   logic        sync_serial_shift_tick;
   logic        pwm_period_match;
   logic [7:0]  pwm_timebase_count;
   logic [7:0]  pwm_timebase_period;
   int          miscompares;
   int          n_compared;
   int          n;
   logic [31:0] rq;
   assign hready = hreadyout;
   pmt_timer pmt_timer_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .irq,
      .sync_serial_shift_tick, .pwm_period_match, .pwm_timebase_count,
      .pwm_timebase_period);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   ////////////////////////////////////////
   task tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Sample at the falling edge, where everything has settled
   task wt;
      int   i;
      logic ok;
      i = 0;
      do begin
         @(negedge hclk);
         ok = hreadyout;
         rq = hrdata;
         @(posedge hclk);
         i++;
      end while (ok !== 1'b1 && i < 40);
      if (ok !== 1'b1) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
   endtask
   task rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk(nm, e, rq);
   endtask
   // Cycles up to and including the next match pulse land in n
   task wm;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (pwm_period_match !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      miscompares = 0;
      n_compared = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd("count", PMT_IDX_COUNT, 32'h0);
      rd("period", PMT_IDX_PERIOD, 32'hff);
      rd("control", PMT_IDX_CONTROL, 32'h0);
      rd("flags", PMT_IDX_IRQ_FLAG, 32'h0);
      rd("unmapped", 8'h01, 32'h0);
      bus(1'b1, PMT_IDX_PERIOD, 32'h5a);
      rd("period rw", PMT_IDX_PERIOD, 32'h5a);
      bus(1'b1, PMT_IDX_COUNT, 32'h33);
      rd("count rw", PMT_IDX_COUNT, 32'h33);
      // Match gap is (period + 1) instruction ticks times the divide
      bus(1'b1, PMT_IDX_PERIOD, 32'h3);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, PMT_IDX_CONTROL, 32'h4 | c);
         wm();
         wm();
         chk("gap", (c == 0) ? 16 : (c == 1) ? 64 : 256, n);
         chk("tb period", 32'h3, pwm_timebase_period);
      end
      bus(1'b1, PMT_IDX_CONTROL, 32'h0);
      bus(1'b1, PMT_IDX_COUNT, 32'h0);
      bus(1'b1, PMT_IDX_IRQ_FLAG, 32'h2);
      bus(1'b1, PMT_IDX_IRQ_EN, 32'h2);
      bus(1'b1, PMT_IDX_INT_CTRL, 32'hc0);
      bus(1'b1, PMT_IDX_CONTROL, 32'h14);
      wm();
      wm();
      rd("flag early", PMT_IDX_IRQ_FLAG, 32'h0);
      wm();
      bus(1'b1, PMT_IDX_CONTROL, 32'h10);
      rd("flag set", PMT_IDX_IRQ_FLAG, 32'h2);
      chk("irq on", 32'h1, irq);
      bus(1'b1, PMT_IDX_IRQ_EN, 32'h0);
      rd("enables", PMT_IDX_IRQ_EN, 32'h0);
      chk("irq masked", 32'h0, irq);
      bus(1'b1, PMT_IDX_IRQ_EN, 32'h2);
      bus(1'b1, PMT_IDX_IRQ_FLAG, 32'h2);
      rd("flag clear", PMT_IDX_IRQ_FLAG, 32'h0);
      chk("irq off", 32'h0, irq);
      // Stopped timer must hold; bit 7 of control reads zero
      bus(1'b1, PMT_IDX_COUNT, 32'h2);
      repeat (40) @(posedge hclk);
      bus(1'b1, PMT_IDX_CONTROL, 32'hfb);
      rd("control rw", PMT_IDX_CONTROL, 32'h7b);
      rd("count held", PMT_IDX_COUNT, 32'h2);
      chk("tb count", 32'h2, pwm_timebase_count);
      tally_and_finish();
   end
endmodule

//--- pmt_timer_properties.sv
// Port checker for the period match timer, bound to pmt_timer.
// Assumes one hclk domain and hresetn asynchronous, active low.
`timescale 1ns/1ps
module pmt_timer_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        sync_serial_shift_tick,
   input wire logic        pwm_period_match,
   input wire logic [7:0]  pwm_timebase_count,
   input wire logic [7:0]  pwm_timebase_period
);
   import pmt_pkg::*;
   // High in the data phase of a write; the write lands at its end
   logic wr_ph_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_q <= 1'b0;
      end else if (hready) begin
         wr_ph_q <= hsel && htrans[1] && hwrite;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_read_wait: assert property (
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (
      hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write was stalled");
   a_data_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("hrdata upper bits set");
   a_tick_same: assert property (
      sync_serial_shift_tick == pwm_period_match)
      else $error("serial tick differs from match");
   a_pulse_single: assert property (
      pwm_period_match |=> !pwm_period_match)
      else $error("match pulse too long");
   a_match_wrap: assert property (pwm_period_match |->
      pwm_timebase_count == 8'h00 &&
      $past(pwm_timebase_count) == $past(pwm_timebase_period))
      else $error("match without count equal to period");
   a_count_step: assert property (
      $changed(pwm_timebase_count) |->
      pwm_timebase_count == $past(pwm_timebase_count) + 8'h01 ||
      pwm_timebase_count == 8'h00 || $past(wr_ph_q))
      else $error("count jumped");
   // Instruction clock is hclk over four, so no two steps are closer
   a_count_slow: assert property ($changed(pwm_timebase_count) &&
      !$past(wr_ph_q) |=> ($stable(pwm_timebase_count) || $past(wr_ph_q))[*3])
      else $error("count stepped faster than instruction clock");
   a_period_write: assert property ($changed(pwm_timebase_period) |->
      $past(wr_ph_q)) else $error("period changed without write");
endmodule

bind pmt_timer pmt_timer_checker pmt_timer_checker_i (.hclk, .hresetn,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
   .sync_serial_shift_tick, .pwm_period_match, .pwm_timebase_count,
   .pwm_timebase_period);
